// >>> verilog/mcs_sequencer.sv
// Overview of operation
// - two cycles per result by default
// - three cycles when configuration needs extra
// - open detect off: no test current
// - open detect on: 8 ms pulse first
// - thermistor autorange: first cycle picks current
// - diode three readings three cycles, else two
// - three-cycle cold junction makes three cycles
// - channel 1 to 10 converts that channel
// - channel zero converts all masked channels
// - multi mode runs highest channel first
// - completion low until all done, skip unassigned
// - mask bytes map channels ten..one
// - settle delay byte times 100 us
// - 0x97 sleeps; chip select wakes
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module mcs_sequencer
    import mcs_pkg::*;
#(
    parameter int unsigned CYCLE_CLOCKS = 32'(CYCLE_CLKS),
    parameter int unsigned OC_CLOCKS    = 32'(OC_PULSE_CLKS),
    parameter int unsigned MUX_CLOCKS   = 32'(MUX_UNIT_CLKS)
) (
    input  wire logic        i_clock,        // 250 MHz clock
    input  wire logic        i_srst,         // sync reset, high
    input  wire logic        i_psel,         // apb select
    input  wire logic        i_penable,      // apb enable
    input  wire logic        i_pwrite,       // apb write
    input  wire logic [11:0] i_paddr,        // apb byte address
    input  wire logic [31:0] i_pwdata,       // apb write data
    output logic      [31:0] o_prdata,       // apb read data
    output logic             o_pready,       // apb ready
    output logic             o_pslverr,      // apb error
    input  wire logic        i_cs_n,         // chip select, wakes
    input  wire logic        i_open_fault,   // front end open sense
    output logic             o_done,         // completion, high idle
    output logic             o_irq,          // masked interrupt
    output logic             o_sleep,        // sleep state
    output logic             o_converting,   // conversion cycle on
    output logic      [3:0]  o_channel,      // active channel
    output logic      [1:0]  o_cycle_index,  // cycle within result
    output logic             o_oc_current,   // open test current
    output logic             o_range_test,   // first cycle of any three-cycle result
    output logic             o_result_valid  // result written pulse
);
    mcs_state_t    state, next_state;
    mcs_chan_cfg_t chan_cfg [NUM_CHANNELS];
    mcs_chan_cfg_t next_cfg [NUM_CHANNELS];
    logic [9:0]  mask, next_mask, pending, next_pending;
    logic [7:0]  mux_delay, next_mux_delay, cmd, next_cmd;
    logic [IRQ_BITS-1:0] irq_status, next_status, irq_mask, next_irqm;
    logic [1:0]  cyc_total, next_total, next_cyc;
    logic [3:0]  next_channel;
    logic [31:0] oc_cnt, next_oc_cnt;
    logic [7:0]  start_cnt, next_start_cnt;
    logic        cs_prev, fault_seen, next_fault_seen;
    logic        next_done, next_sleep, next_conv, next_oc, next_range;
    logic        next_valid, next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic        tmr_load, tmr_done, launch, launch_three;
    logic [31:0] tmr_count;
    logic [9:0]  idx;
    logic        mapped, wr, rd, cmd_wr;
    logic [7:0]  wbyte;
    mcs_chan_cfg_t cur;

    function automatic logic [3:0] top_channel(logic [9:0] v);
        logic [3:0] t;
        t = 4'h0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (v[i]) t = 4'(i + 1);
        end
        return t;
    endfunction : top_channel

    function automatic logic is_three(logic [3:0] ch);
        mcs_chan_cfg_t c, j;
        logic t;
        c = chan_cfg[ch - 4'h1];
        t = mcs_needs_three(c);
        if (c.sensor == SENSOR_THERMOCOUPLE && c.cj_channel != 4'h0
            && c.cj_channel <= 4'(NUM_CHANNELS)) begin
            j = chan_cfg[c.cj_channel - 4'h1];
            t = t | mcs_needs_three(j);
        end
        return t;
    endfunction : is_three

    mcs_cycle_timer #(.W(32)) mcs_cycle_timer_i (
        .i_clock (i_clock),
        .i_srst  (i_srst),
        .i_load  (tmr_load),
        .i_count (tmr_count),
        .o_done  (tmr_done)
    );

    assign idx    = i_paddr[11:2];
    assign wr     = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;
    assign rd     = i_psel && i_penable && o_pready && !i_pwrite;
    assign wbyte  = i_pwdata[7:0];
    assign cmd_wr = wr && idx == IDX_CMD;
    assign cur    = chan_cfg[(o_channel == 4'h0) ? 4'h0 : o_channel - 4'h1];

    always_comb begin
        mapped = i_paddr[1:0] == 2'h0
            && (idx == IDX_CMD || idx == IDX_IRQ_STATUS
             || idx == IDX_IRQ_MASK || idx == IDX_SEQ_STATE
             || idx == IDX_MASK_HI || idx == IDX_MASK_LO
             || idx == IDX_MUX_DELAY
             || (idx > IDX_CHAN_BASE
                 && idx <= IDX_CHAN_BASE + 10'(NUM_CHANNELS)));
        next_prdata = 32'h0;
        case (1'b1)
            idx == IDX_CMD:        next_prdata[7:0] = cmd;
            idx == IDX_IRQ_STATUS: next_prdata[IRQ_BITS-1:0] = irq_status;
            idx == IDX_IRQ_MASK:   next_prdata[IRQ_BITS-1:0] = irq_mask;
            idx == IDX_SEQ_STATE:  next_prdata[14:0] = {pending, state};
            idx == IDX_MASK_HI:    next_prdata[1:0] = mask[9:8];
            idx == IDX_MASK_LO:    next_prdata[7:0] = mask[7:0];
            idx == IDX_MUX_DELAY:  next_prdata[7:0] = mux_delay;
            default: begin
                if (mapped && idx > IDX_CHAN_BASE) begin
                    next_prdata[9:0] = chan_cfg[4'(idx - IDX_CHAN_BASE) - 4'h1];
                end
            end
        endcase
        next_pready  = i_psel && !i_penable;
        next_pslverr = i_psel && !i_penable && !mapped;
        if (!next_pready) begin
            next_prdata = 32'h0;
        end
    end

    // register writes, status set wins over read clear
    always_comb begin
        next_mask      = mask;
        next_mux_delay = mux_delay;
        next_irqm      = irq_mask;
        next_cfg       = chan_cfg;
        next_status    = irq_status;
        // read clears only the bits it reported
        if (rd && idx == IDX_IRQ_STATUS) begin
            next_status = irq_status & ~o_prdata[IRQ_BITS-1:0];
        end
        if (wr) begin
            if (idx == IDX_MASK_HI)   next_mask[9:8] = wbyte[1:0];
            if (idx == IDX_MASK_LO)   next_mask[7:0] = wbyte;
            if (idx == IDX_MUX_DELAY) next_mux_delay = wbyte;
            if (idx == IDX_IRQ_MASK)  next_irqm = wbyte[IRQ_BITS-1:0];
            if (idx > IDX_CHAN_BASE && idx <= IDX_CHAN_BASE + 10'h00a) begin
                next_cfg[4'(idx - IDX_CHAN_BASE) - 4'h1] = i_pwdata[9:0];
            end
        end
        if (state == ST_CONV && tmr_done && fault_seen) begin
            next_status[IRQ_OPEN_FAULT] = 1'b1;
        end
        if (state == ST_CONV && tmr_done && pending == 10'h0
            && o_cycle_index == cyc_total - 2'h1) begin
            next_status[IRQ_SEQ_DONE] = 1'b1;
        end
        if (cmd_wr && wbyte != CMD_SLEEP && wbyte[CMD_START_BIT]
            && (wbyte[4:0] > CMD_CH_MAX || state != ST_IDLE)) begin
            next_status[IRQ_CMD_REJECT] = 1'b1;
        end
        if (cmd_wr && wbyte[CMD_START_BIT] && state == ST_IDLE
            && wbyte[4:0] <= CMD_CH_MAX && next_pending == 10'h0) begin
            next_status[IRQ_SEQ_DONE] = 1'b1;
        end
    end

    // sequencer
    always_comb begin
        logic [9:0] assigned_v;
        assigned_v      = '0;
        next_state      = state;
        next_pending    = pending;
        next_cmd        = cmd;
        next_total      = cyc_total;
        next_cyc        = o_cycle_index;
        next_channel    = o_channel;
        next_done       = o_done;
        next_conv       = o_converting;
        next_valid      = 1'b0;
        next_start_cnt  = start_cnt;
        next_fault_seen = fault_seen;
        next_oc_cnt     = (oc_cnt != 32'h0) ? oc_cnt - 32'h1 : 32'h0;
        tmr_load        = 1'b0;
        tmr_count       = 32'h0;
        launch          = 1'b0;
        launch_three    = 1'b0;
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            assigned_v[i] = chan_cfg[i].assigned;
        end
        if (cmd_wr) next_cmd = wbyte;
        case (state)
            ST_START: begin
                next_done      = 1'b0;
                next_start_cnt = start_cnt + 8'h1;
                if (start_cnt == 8'(STARTUP_CLKS - 1)) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end
            end
            ST_IDLE: begin
                if (cmd_wr && wbyte == CMD_SLEEP) begin
                    next_state = ST_SLEEP;
                end else if (cmd_wr && wbyte[CMD_START_BIT]
                             && wbyte[4:0] <= CMD_CH_MAX) begin
                    if (wbyte[4:0] == CMD_CH_MULTI) begin
                        next_pending = mask & assigned_v;
                    end else begin
                        next_pending = (10'h1 << (wbyte[4:0] - 5'h1))
                                       & assigned_v;
                    end
                    next_done = next_pending == 10'h0;
                    if (next_done) next_cmd[CMD_START_BIT] = 1'b0;
                end else if (pending != 10'h0) begin
                    launch = 1'b1;
                end
            end
            ST_SETTLE: begin
                if (tmr_done) begin
                    next_state = ST_CONV;
                    next_conv  = 1'b1;
                    tmr_load   = 1'b1;
                    tmr_count  = CYCLE_CLOCKS;
                    if (o_cycle_index == 2'h0 && cyc_total == 2'h3
                        && cur.sensor == SENSOR_THERMOCOUPLE
                        && cur.open_circuit_detect_select) begin
                        next_oc_cnt = OC_CLOCKS;
                    end
                end
            end
            ST_CONV: begin
                if (tmr_done) begin
                    next_conv = 1'b0;
                    // open sensed after the test cycle
                    if (o_cycle_index == 2'h0 && cyc_total == 2'h3
                        && cur.sensor == SENSOR_THERMOCOUPLE
                        && cur.open_circuit_detect_select) begin
                        next_fault_seen = i_open_fault;
                    end
                    if (o_cycle_index != cyc_total - 2'h1) begin
                        next_cyc   = o_cycle_index + 2'h1;
                        next_state = ST_SETTLE;
                        tmr_load   = 1'b1;
                        tmr_count  = 32'(mux_delay * MUX_CLOCKS);
                    end else begin
                        next_valid = 1'b1;
                        if (pending != 10'h0) begin
                            launch = 1'b1;
                        end else begin
                            next_state = ST_IDLE;
                            next_done  = 1'b1;
                            next_cmd[CMD_START_BIT] = 1'b0;
                        end
                    end
                end
            end
            ST_SLEEP: begin
                if (cs_prev && !i_cs_n) begin
                    next_state     = ST_START;
                    next_start_cnt = 8'h0;
                    next_done      = 1'b0;
                end
            end
            default: next_state = ST_START;
        endcase
        if (launch) begin
            next_channel = top_channel(pending);
            next_pending = pending & ~(10'h1 << (next_channel - 4'h1));
            launch_three = is_three(next_channel);
            next_total   = launch_three ? 2'h3 : 2'h2;
            next_cyc     = 2'h0;
            next_fault_seen = 1'b0;
            next_state   = ST_SETTLE;
            tmr_load     = 1'b1;
            tmr_count    = 32'(mux_delay * MUX_CLOCKS);
        end
        next_sleep = next_state == ST_SLEEP;
        // current only when selected, 8 ms
        next_oc    = next_oc_cnt != 32'h0;
        // first of three cycles is the test cycle
        next_range = next_conv && next_cyc == 2'h0 && next_total == 2'h3;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state          <= ST_START;
            chan_cfg       <= '{default: '0};
            mask           <= 10'h0;
            mux_delay      <= MUX_DELAY_RESET;
            cmd            <= CMD_RESET;
            irq_status     <= '0;
            irq_mask       <= '0;
            pending        <= 10'h0;
            cyc_total      <= 2'h2;
            oc_cnt         <= 32'h0;
            start_cnt      <= 8'h0;
            cs_prev        <= 1'b1;
            fault_seen     <= 1'b0;
            o_prdata       <= 32'h0;
            o_pready       <= 1'b0;
            o_pslverr      <= 1'b0;
            o_done         <= 1'b0;
            o_irq          <= 1'b0;
            o_sleep        <= 1'b0;
            o_converting   <= 1'b0;
            o_channel      <= 4'h0;
            o_cycle_index  <= 2'h0;
            o_oc_current   <= 1'b0;
            o_range_test   <= 1'b0;
            o_result_valid <= 1'b0;
        end else begin
            state          <= next_state;
            chan_cfg       <= next_cfg;
            mask           <= next_mask;
            mux_delay      <= next_mux_delay;
            cmd            <= next_cmd;
            irq_status     <= next_status;
            irq_mask       <= next_irqm;
            pending        <= next_pending;
            cyc_total      <= next_total;
            oc_cnt         <= next_oc_cnt;
            start_cnt      <= next_start_cnt;
            cs_prev        <= i_cs_n;
            fault_seen     <= next_fault_seen;
            o_prdata       <= next_prdata;
            o_pready       <= next_pready;
            o_pslverr      <= next_pslverr;
            o_done         <= next_done;
            o_irq          <= |(next_status & next_irqm);
            o_sleep        <= next_sleep;
            o_converting   <= next_conv;
            o_channel      <= next_channel;
            o_cycle_index  <= next_cyc;
            o_oc_current   <= next_oc;
            o_range_test   <= next_range;
            o_result_valid <= next_valid;
        end
    end

    property p_done_low;
        @(posedge i_clock) disable iff (i_srst)
        (state == ST_SETTLE || state == ST_CONV) |-> !o_done;
    endproperty
    a_done_low: assert property (p_done_low)
        else $error("completion high during conversion");

    property p_two_cycles;
        @(posedge i_clock) disable iff (i_srst)
        launch && !launch_three |=> cyc_total == 2'h2 && o_cycle_index == 0;
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("two-cycle result not set up");

    property p_three_cycles;
        @(posedge i_clock) disable iff (i_srst)
        launch && launch_three |=> cyc_total == 2'h3;
    endproperty
    a_three_cycles: assert property (p_three_cycles)
        else $error("three-cycle result not set up");

    property p_oc_only_selected;
        @(posedge i_clock) disable iff (i_srst)
        o_oc_current |-> cur.open_circuit_detect_select
            && cur.sensor == SENSOR_THERMOCOUPLE && o_cycle_index == 2'h0;
    endproperty
    a_oc_only_selected: assert property (p_oc_only_selected)
        else $error("test current outside open detect cycle");

    property p_oc_pulse;
        @(posedge i_clock) disable iff (i_srst)
        $rose(o_oc_current) |-> o_converting && o_oc_current[*8];
    endproperty
    a_oc_pulse: assert property (p_oc_pulse)
        else $error("open detect pulse too short");

    property p_reject;
        @(posedge i_clock) disable iff (i_srst)
        cmd_wr && wbyte[CMD_START_BIT] && wbyte[4:0] > CMD_CH_MAX
            && wbyte != CMD_SLEEP |=> $stable(pending)
            && irq_status[IRQ_CMD_REJECT] && !launch;
    endproperty
    a_reject: assert property (p_reject)
        else $error("bad channel command not refused");

    property p_order;
        @(posedge i_clock) disable iff (i_srst)
        launch |=> (pending >> o_channel) == 10'h0 && o_channel != 4'h0;
    endproperty
    a_order: assert property (p_order)
        else $error("lower channel launched before higher");

    property p_sleep;
        @(posedge i_clock) disable iff (i_srst)
        cmd_wr && wbyte == CMD_SLEEP && state == ST_IDLE |=> o_sleep;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep command did not sleep");

    property p_mask_read;
        @(posedge i_clock) disable iff (i_srst)
        i_psel && !i_penable && idx == IDX_MASK_HI && i_paddr[1:0] == 0
            |=> o_prdata == {30'h0, $past(mask[9:8])};
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask high byte read wrong");

    property p_irq;
        @(posedge i_clock) disable iff (i_srst)
        ##1 o_irq == |(irq_status & irq_mask);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with status");
endmodule : mcs_sequencer

// >>> verilog/mcs_pkg.sv
package mcs_pkg;
    localparam int unsigned NUM_CHANNELS = 10;
    localparam int unsigned CLK_PERIOD_NS = 4;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CMD        = 10'h000;
    localparam logic [9:0] IDX_CHAN_BASE  = 10'h0e0;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h0f0;
    localparam logic [9:0] IDX_IRQ_MASK   = 10'h0f1;
    localparam logic [9:0] IDX_SEQ_STATE  = 10'h0f2;
    localparam logic [9:0] IDX_MASK_HI    = 10'h0f6;
    localparam logic [9:0] IDX_MASK_LO    = 10'h0f7;
    localparam logic [9:0] IDX_MUX_DELAY  = 10'h0ff;

    // command byte layout
    localparam int unsigned CMD_START_BIT  = 6;
    localparam logic [7:0]  CMD_SLEEP      = 8'h97;
    localparam logic [4:0]  CMD_CH_MULTI   = 5'h00;
    localparam logic [4:0]  CMD_CH_MAX     = 5'h0a;

    // interrupt status bit positions
    localparam int unsigned IRQ_SEQ_DONE   = 0;
    localparam int unsigned IRQ_OPEN_FAULT = 1;
    localparam int unsigned IRQ_CMD_REJECT = 2;
    localparam int unsigned IRQ_BITS       = 3;

    localparam logic [7:0] CMD_RESET       = 8'h00;
    localparam logic [7:0] MUX_DELAY_RESET = 8'h00;

    // timing, figures in ns, counts derived
    localparam longint TWO_CYCLE_MAX_NS   = 167_200_000;
    localparam longint THREE_CYCLE_MAX_NS = 251_000_000;
    localparam longint OC_PULSE_NS        = 8_000_000;
    localparam longint MUX_UNIT_NS        = 100_000;
    localparam longint CYCLE2_CLKS = TWO_CYCLE_MAX_NS / 2 / CLK_PERIOD_NS;
    localparam longint CYCLE3_CLKS = THREE_CYCLE_MAX_NS / 3 / CLK_PERIOD_NS;
    localparam longint CYCLE_CLKS  =
        (CYCLE2_CLKS < CYCLE3_CLKS) ? CYCLE2_CLKS : CYCLE3_CLKS;
    localparam longint OC_PULSE_CLKS  = (OC_PULSE_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
    localparam longint MUX_UNIT_CLKS  = (MUX_UNIT_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
    localparam longint STARTUP_CLKS   = 64;

    localparam logic [1:0] SENSOR_THERMOCOUPLE = 2'h0;
    localparam logic [1:0] SENSOR_RTD          = 2'h1;
    localparam logic [1:0] SENSOR_THERMISTOR   = 2'h2;
    localparam logic [1:0] SENSOR_DIODE        = 2'h3;

    typedef enum logic [4:0] {
        ST_START  = 5'b00001,
        ST_IDLE   = 5'b00010,
        ST_SETTLE = 5'b00100,
        ST_CONV   = 5'b01000,
        ST_SLEEP  = 5'b10000
    } mcs_state_t;

    typedef struct packed {
        logic [3:0] cj_channel;
        logic       three_reading;
        logic       autorange;
        logic       open_circuit_detect_select;
        logic [1:0] sensor;
        logic       assigned;
    } mcs_chan_cfg_t;

    function automatic logic mcs_needs_three(mcs_chan_cfg_t c);
        return (c.sensor == SENSOR_THERMOCOUPLE
                && c.open_circuit_detect_select)
            || (c.sensor == SENSOR_THERMISTOR && c.autorange)
            || (c.sensor == SENSOR_DIODE && c.three_reading);
    endfunction : mcs_needs_three
endpackage : mcs_pkg

// >>> verilog/mcs_cycle_timer.sv
`timescale 1ns/1ps
module mcs_cycle_timer #(
    parameter int unsigned W = 32
) (
    input  wire logic         i_clock,   // system clock
    input  wire logic         i_srst,    // sync reset
    input  wire logic         i_load,    // start a new interval
    input  wire logic [W-1:0] i_count,   // interval in clocks
    output logic              o_done     // pulse at interval end
);
    logic [W-1:0] cnt;
    logic         busy;
    logic [W-1:0] next_cnt;
    logic         next_busy;
    logic         next_done;

    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (i_load) begin
            next_cnt  = (i_count == '0) ? W'(1) : i_count;
            next_busy = 1'b1;
        end else if (busy) begin
            next_cnt = cnt - W'(1);
            if (cnt == W'(1)) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            cnt    <= '0;
            busy   <= 1'b0;
            o_done <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            busy   <= next_busy;
            o_done <= next_done;
        end
    end
endmodule : mcs_cycle_timer

// >>> tb/mcs_front.sv
`timescale 1ns/1ps
module mcs_front (
    input  wire logic i_clock,      // clock
    input  wire logic i_broken,     // sensor open
    input  wire logic i_oc_current, // test current
    output logic      o_open_fault  // open sensed
);
    // fault only shows once test current has flowed
    always @(posedge i_clock)
        o_open_fault <= i_broken & (i_oc_current | o_open_fault);
endmodule : mcs_front

// >>> tb/multi_channel_conversion_sequencer_bench.sv
`timescale 1ns/1ps
module multi_channel_conversion_sequencer_bench;
    import mcs_pkg::*;
    logic        i_clock = 1'b0, i_srst = 1'b1, i_cs_n = 1'b1, brk = 1'b0;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, cq = 1'b0;
    logic        o_pready, o_pslverr, i_open_fault, o_done, o_irq, o_sleep;
    localparam int OCK = 8;
    localparam int MXK = 2;
    logic        o_converting, o_oc_current, o_result_valid, o_range_test;
    logic        rt = 1'b0;
    logic [3:0]  o_channel, lc = 4'h0;
    logic [1:0]  o_cycle_index, li = 2'h0;
    logic [14:0] gv;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0, o_prdata;
    logic [32:0] xq[$];
    logic [15:0] seed = 16'h7b4e;
    int          errors = 0, tests_run = 0, nc = 0, ch, n, oc = 0, lo = 0;
    int          md = 0;
    // cycles per result, channel one first
    int          ncy[10] = '{2, 2, 3, 3, 2, 3, 2, 0, 0, 3};
    logic [9:0]  cfg[10] = '{10'h003, 10'h007, 10'h281, 10'h015, 10'h005,
                             10'h009, 10'h001, 10'h000, 10'h000, 10'h027};
    mcs_sequencer #(.CYCLE_CLOCKS(20), .OC_CLOCKS(OCK), .MUX_CLOCKS(MXK))
        mcs_sequencer_i (.i_clock, .i_srst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_cs_n,
        .i_open_fault, .o_done, .o_irq, .o_sleep, .o_converting, .o_channel,
        .o_cycle_index, .o_oc_current, .o_range_test, .o_result_valid);
    mcs_front mcs_front_i (.i_clock, .i_broken(brk),
        .i_oc_current(o_oc_current), .o_open_fault(i_open_fault));
    initial forever #2 i_clock = ~i_clock;
    task automatic chk(input logic [32:0] g, input logic [32:0] x);
        tests_run++;
        if (g !== x) begin
            errors++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic finish_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    // one transfer; a read compares {pslverr, prdata}
    task automatic rw(input logic w, logic [9:0] a, logic [32:0] x);
        @(posedge i_clock);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, 2'b00, x[31:0]};
        @(posedge i_clock);
        i_penable <= 1'b1;
        do @(posedge i_clock); while (o_pready !== 1'b1);
        if (!w) chk({o_pslverr, o_prdata}, x);
        {i_psel, i_penable} <= 2'b00;
    endtask : rw
    task automatic wait_done;
        repeat (2) @(posedge i_clock);
        for (n = 0; o_done !== 1'b1 && n < 9000; n++) @(posedge i_clock);
        chk(33'(o_done), 33'h1);
    endtask : wait_done
    task automatic expect_ch(input int c);
        if (ncy[c - 1] > 0) xq.push_back(33'({4'(c), 4'(ncy[c - 1]),
            2'(ncy[c - 1] - 1), ncy[c - 1] == 3,
            4'((cfg[c - 1][3:0] == 4'h9) ? OCK : 0)}));
    endtask : expect_ch
    // channel, cycles, last index, test cycle seen, test current clocks
    assign gv = {lc, 4'(nc), li, rt, 4'(oc)};
    always @(posedge i_clock) begin
        cq <= o_converting;
        nc <= o_result_valid ? 0 : nc + int'(o_converting && !cq);
        oc <= o_result_valid ? 0 : oc + int'(o_oc_current);
        rt <= !o_result_valid && (rt || o_range_test);
        lo <= o_converting ? 0 : lo + 1;
        if (o_converting) {lc, li} <= {o_channel, o_cycle_index};
        if (o_converting && !cq) chk(33'(lo >= MXK * md), 33'h1);
        if (o_result_valid) chk(33'(gv), xq.pop_front());
    end
    initial begin
        repeat (30000) @(posedge i_clock);
        errors++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge i_clock);
        chk(33'(o_done), 33'h0);
        i_srst <= 1'b0;
        wait_done();
        foreach (cfg[i]) rw(1'b1, IDX_CHAN_BASE + 10'(i + 1), 33'(cfg[i]));
        rw(1'b1, IDX_MASK_HI, 33'h2);
        rw(1'b1, IDX_MASK_LO, 33'hff);
        rw(1'b1, IDX_IRQ_MASK, 33'h6);
        rw(1'b0, IDX_MASK_LO, 33'hff);
        for (int c = 10; c > 0; c--) expect_ch(c);
        brk <= 1'b1;
        rw(1'b1, IDX_CMD, 33'h40);
        @(posedge i_clock);
        chk(33'(o_done), 33'h0);
        wait_done();
        chk(33'(o_irq), 33'h1);
        rw(1'b0, IDX_IRQ_STATUS, 33'h3);
        brk <= 1'b0;
        repeat (4) begin
            seed = lfsr(seed);
            ch = int'(seed[7:4]) % 10 + 1;
            md = int'(seed[1:0]);
            expect_ch(ch);
            rw(1'b1, IDX_MUX_DELAY, 33'(md));
            rw(1'b1, IDX_CMD, 33'(8'h40 | 8'(ch)));
            wait_done();
            chk(33'(o_irq), 33'h0);
            rw(1'b0, IDX_IRQ_STATUS, 33'h1);
        end
        rw(1'b1, IDX_CMD, 33'h4b);
        rw(1'b0, IDX_IRQ_STATUS, 33'h4);
        rw(1'b0, 10'h100, 33'h1_0000_0000);
        rw(1'b1, IDX_CMD, 33'h97);
        repeat (2) @(posedge i_clock);
        chk(33'(o_sleep), 33'h1);
        i_cs_n <= 1'b0;
        wait_done();
        chk(33'(xq.size()), 33'h0);
        finish_test();
    end
endmodule : multi_channel_conversion_sequencer_bench
